// ===== dma_alias_pkg.sv
// constants, field layout and carrier types for the dma channel control block
package dma_alias_pkg;
	localparam int          CHANNELS_DEF   = 12;
	localparam int          ADDR_W         = 12;
	localparam int          CHAN_LSB       = 6;
	localparam int          CHAN_W         = 4;
	// byte offsets of the sixteen views inside one 0x40 channel block
	localparam logic [5:0]  OFS_SOURCE_POINTER     = 6'h00;
	localparam logic [5:0]  OFS_DEST_POINTER       = 6'h04;
	localparam logic [5:0]  OFS_COUNT              = 6'h08;
	localparam logic [5:0]  OFS_CONTROL_TRIGGER    = 6'h0c;
	localparam logic [5:0]  OFS_ALIAS1_CONTROL     = 6'h10;
	localparam logic [5:0]  OFS_ALIAS1_SOURCE      = 6'h14;
	localparam logic [5:0]  OFS_ALIAS1_DEST        = 6'h18;
	localparam logic [5:0]  OFS_ALIAS1_COUNT_TRIG  = 6'h1c;
	localparam logic [5:0]  OFS_ALIAS2_CONTROL     = 6'h20;
	localparam logic [5:0]  OFS_ALIAS2_COUNT       = 6'h24;
	localparam logic [5:0]  OFS_ALIAS2_SOURCE      = 6'h28;
	localparam logic [5:0]  OFS_ALIAS2_DEST_TRIG   = 6'h2c;
	localparam logic [5:0]  OFS_ALIAS3_CONTROL     = 6'h30;
	localparam logic [5:0]  OFS_ALIAS3_DEST        = 6'h34;
	localparam logic [5:0]  OFS_ALIAS3_COUNT       = 6'h38;
	localparam logic [5:0]  OFS_ALIAS3_SOURCE_TRIG = 6'h3c;
	// control word fields
	localparam int          CHAIN_LSB      = 11;
	localparam int          WRAP_SEL_BIT   = 10;
	localparam int          WRAP_LSB       = 6;
	localparam int          DINC_BIT       = 5;
	localparam int          SINC_BIT       = 4;
	localparam int          WIDTH_LSB      = 2;
	localparam int          PRIO_BIT       = 1;
	localparam int          EN_BIT         = 0;
	localparam int          BUSY_BIT       = 24;
	localparam logic [31:0] CTRL_WR_MASK   = 32'h0000_7fff;
	localparam logic [1:0]  WIDTH_BYTE     = 2'h0;
	localparam logic [1:0]  WIDTH_HALF     = 2'h1;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	typedef enum logic [1:0] {KIND_SRC, KIND_DST, KIND_CNT, KIND_CTRL} view_kind_e;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] reload;
		logic [31:0] count;
		logic        busy;
	} chan_s;

	typedef struct packed {
		logic [31:0] src;
		logic [31:0] dst;
		logic [1:0]  width;
		logic [3:0]  chan;
	} xfer_s;
endpackage

// ===== dma_channel_ctrl.sv
// multi-channel dma control registers, alias views, trigger/chain logic and issue scheduler
//
// How it works
// - completion triggers the channel named by chain_target
// - chain_target equal own index disables chaining
// - wrap_select picks source (0) or destination (1)
// - wrap keeps all but low n pointer bits
// - wrap size zero means free advance
// - ring regions span 2 to 32768 bytes
// - dest_increment advances destination, else fixed
// - src_increment advances source, else fixed
// - transfer_width selects byte, halfword or word
// - pointers advance by 1, 2 or 4
// - all high channels, then one low, repeat
// - priority orders scheduling only, not bus
// - enabled channel goes busy on trigger
// - disabled channel ignores triggers, pauses, stays busy
// - nonzero trigger-view write stores, reloads, starts
// - alias set one at 0x010 to 0x01c
// - alias set two at 0x020 to 0x02c
// - channel blocks repeat every 0x40 bytes
// - pointer aliases share the primary storage
// - each trigger copies reload into live counter
// - busy rises on start, falls after last
`timescale 1ns/10ps
module dma_channel_ctrl
	import dma_alias_pkg::*;
#(
	parameter int N = CHANNELS_DEF
)(
	input  wire logic              aclk,        // system clock, 50 MHz
	input  wire logic              aresetn,     // synchronous reset, active low
	input  wire logic [ADDR_W-1:0] awaddr,      // write address
	input  wire logic [2:0]        awprot,      // write protection, unused
	input  wire logic              awvalid,     // write address valid
	output logic                   awready,     // write address ready
	input  wire logic [31:0]       wdata,       // write data
	input  wire logic [3:0]        wstrb,       // write byte strobes
	input  wire logic              wvalid,      // write data valid
	output logic                   wready,      // write data ready
	output logic [1:0]             bresp,       // write response
	output logic                   bvalid,      // write response valid
	input  wire logic              bready,      // write response ready
	input  wire logic [ADDR_W-1:0] araddr,      // read address
	input  wire logic [2:0]        arprot,      // read protection, unused
	input  wire logic              arvalid,     // read address valid
	output logic                   arready,     // read address ready
	output logic [31:0]            rdata,       // read data
	output logic [1:0]             rresp,       // read response
	output logic                   rvalid,      // read data valid
	input  wire logic              rready,      // read data ready
	output logic                   xfer_valid,  // transfer request to the fabric
	input  wire logic              xfer_ready,  // fabric has done the transfer
	output xfer_s                  xfer,        // addresses, width and channel
	output logic [N-1:0]           chan_busy    // busy flag per channel
);
	typedef struct packed {
		chan_s [N-1:0]     ch;
		logic              aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_full;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              xvalid;
		xfer_s             xfer;
		logic [4:0]        hi_ptr;
		logic [3:0]        lo_ptr;
	} state_s;

	state_s       s_reg;
	state_s       s_next;
	logic         wr_fire;
	logic         wr_hit;
	logic [31:0]  wr_val;
	logic [N-1:0] trig_sw;
	logic [N-1:0] trig_chain;

	function automatic view_kind_e kind_of(input logic [5:0] ofs);
		view_kind_e k;
		k = KIND_CTRL;
		unique case (ofs)
			OFS_SOURCE_POINTER, OFS_ALIAS1_SOURCE, OFS_ALIAS2_SOURCE,
			OFS_ALIAS3_SOURCE_TRIG: k = KIND_SRC;
			OFS_DEST_POINTER, OFS_ALIAS1_DEST, OFS_ALIAS2_DEST_TRIG,
			OFS_ALIAS3_DEST: k = KIND_DST;
			OFS_COUNT, OFS_ALIAS1_COUNT_TRIG, OFS_ALIAS2_COUNT,
			OFS_ALIAS3_COUNT: k = KIND_CNT;
			default: k = KIND_CTRL;
		endcase
		return k;
	endfunction

	// the last view of every set of four is the trigger view
	function automatic logic is_trig(input logic [5:0] ofs);
		return ofs == OFS_CONTROL_TRIGGER || ofs == OFS_ALIAS1_COUNT_TRIG
			|| ofs == OFS_ALIAS2_DEST_TRIG || ofs == OFS_ALIAS3_SOURCE_TRIG;
	endfunction

	function automatic logic [31:0] read_view(input chan_s c, input logic [5:0] ofs);
		logic [31:0] v;
		v = '0;
		unique case (kind_of(ofs))
			KIND_SRC:  v = c.src;
			KIND_DST:  v = c.dst;
			KIND_CNT:  v = c.count;
			KIND_CTRL:
			begin
				v = c.ctrl & CTRL_WR_MASK;
				v[BUSY_BIT] = c.busy;
			end
		endcase
		return v;
	endfunction

	function automatic logic [31:0] width_bytes(input logic [1:0] w);
		logic [31:0] b;
		b = 32'h0000_0004; // reserved code 0x3 behaves as word
		if (w == WIDTH_BYTE)
			b = 32'h0000_0001;
		else if (w == WIDTH_HALF)
			b = 32'h0000_0002;
		return b;
	endfunction

	// wrap keeps the pointer inside a naturally aligned 2^n byte ring
	function automatic logic [31:0] advance(input logic [31:0] p, input logic inc,
		input logic wrap, input logic [3:0] n, input logic [1:0] w);
		logic [31:0] sum;
		logic [31:0] mask;
		sum = inc ? p + width_bytes(w) : p;
		mask = (32'h0000_0001 << n) - 32'h0000_0001; // n up to 15 gives 32768
		if (wrap && n != 4'h0)
			sum = (p & ~mask) | (sum & mask);
		return sum;
	endfunction

	// first set bit at or after start; with wrap the search goes round
	function automatic logic [4:0] find_first(input logic [N-1:0] m, input logic [4:0] start,
		input logic wrap);
		logic [4:0] r;
		int         idx;
		r = '0;
		for (int k = N - 1; k >= 0; k--)
		begin
			idx = int'(start) + k;
			if (wrap && idx >= N)
				idx = idx - N;
			if (idx < N && m[idx])
				r = {1'b1, idx[3:0]};
		end
		return r;
	endfunction

	always_comb
	begin
		logic [3:0]   c;
		logic [3:0]   tgt;
		logic [3:0]   wr_ch;
		logic [5:0]   wr_ofs;
		logic [31:0]  old;
		logic [N-1:0] elig;
		logic [4:0]   f;
		logic         hit_r;
		s_next = s_reg;
		c = s_reg.xfer.chan;
		tgt = '0;
		wr_ch = s_reg.aw_addr[CHAN_LSB +: CHAN_W];
		wr_ofs = s_reg.aw_addr[CHAN_LSB-1:0];
		old = '0;
		elig = '0;
		f = '0;
		hit_r = 1'b0;
		wr_val = '0;
		trig_sw = '0;
		trig_chain = '0;

		// transfer taken by the fabric: step pointers and count
		if (s_reg.xvalid && xfer_ready)
		begin
			s_next.xvalid = 1'b0;
			s_next.ch[c].src = advance(s_reg.ch[c].src, s_reg.ch[c].ctrl[SINC_BIT],
				!s_reg.ch[c].ctrl[WRAP_SEL_BIT], s_reg.ch[c].ctrl[WRAP_LSB +: 4],
				s_reg.ch[c].ctrl[WIDTH_LSB +: 2]);
			s_next.ch[c].dst = advance(s_reg.ch[c].dst, s_reg.ch[c].ctrl[DINC_BIT],
				s_reg.ch[c].ctrl[WRAP_SEL_BIT], s_reg.ch[c].ctrl[WRAP_LSB +: 4],
				s_reg.ch[c].ctrl[WIDTH_LSB +: 2]);
			s_next.ch[c].count = s_reg.ch[c].count - 32'h0000_0001;
		end

		// sequence end: busy drops once the count is spent and nothing is in flight
		for (int i = 0; i < N; i++)
		begin
			if (s_reg.ch[i].busy && s_reg.ch[i].count == 32'h0 && !(s_reg.xvalid && c == i))
			begin
				s_next.ch[i].busy = 1'b0;
				tgt = s_reg.ch[i].ctrl[CHAIN_LSB +: 4];
				if (tgt != 4'(i) && int'(tgt) < N)
					trig_chain[tgt] = 1'b1;
			end
		end

		// axi write channel
		if (s_reg.bvalid && bready)
			s_next.bvalid = 1'b0;
		if (awvalid && s_reg.awready)
		begin
			s_next.aw_full = 1'b1;
			s_next.aw_addr = awaddr;
		end
		if (wvalid && s_reg.wready)
		begin
			s_next.w_full = 1'b1;
			s_next.w_data = wdata;
			s_next.w_strb = wstrb;
		end
		wr_fire = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
		wr_hit = int'(s_reg.aw_addr[ADDR_W-1:CHAN_LSB]) < N;
		if (wr_fire)
		begin
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (wr_hit)
		begin
			old = kind_of(wr_ofs) == KIND_CNT ? s_next.ch[wr_ch].reload
				: read_view(s_next.ch[wr_ch], wr_ofs);
			for (int b = 0; b < 4; b++)
				wr_val[8*b +: 8] = s_reg.w_strb[b] ? s_reg.w_data[8*b +: 8] : old[8*b +: 8];
		end
		if (wr_fire && wr_hit)
		begin
			unique case (kind_of(wr_ofs))
				KIND_SRC:  s_next.ch[wr_ch].src = wr_val;
				KIND_DST:  s_next.ch[wr_ch].dst = wr_val;
				KIND_CNT:  s_next.ch[wr_ch].reload = wr_val;
				KIND_CTRL: s_next.ch[wr_ch].ctrl = wr_val & CTRL_WR_MASK;
			endcase
			if (is_trig(wr_ofs) && wr_val != 32'h0)
				trig_sw[wr_ch] = 1'b1;
		end

		// start: chained and software triggers take the same path
		for (int i = 0; i < N; i++)
		begin
			if ((trig_sw[i] || trig_chain[i]) && s_next.ch[i].ctrl[EN_BIT])
			begin
				s_next.ch[i].count = s_next.ch[i].reload;
				s_next.ch[i].busy = 1'b1;
			end
		end

		// issue scheduling; priority only orders the picks, the fabric port is shared
		for (int i = 0; i < N; i++)
			elig[i] = s_next.ch[i].busy && s_next.ch[i].ctrl[EN_BIT]
				&& s_next.ch[i].count != 32'h0;
		if (!s_next.xvalid)
		begin
			f = find_first(elig & hi_mask(s_next), s_reg.hi_ptr, 1'b0);
			if (f[4])
				s_next.hi_ptr = 5'(f[3:0]) + 5'h01;
			else
			begin
				s_next.hi_ptr = 5'h00;
				f = find_first(elig & ~hi_mask(s_next), 5'(s_reg.lo_ptr), 1'b1);
				if (f[4])
					s_next.lo_ptr = int'(f[3:0]) + 1 >= N ? 4'h0 : f[3:0] + 4'h1;
			end
			if (f[4])
			begin
				s_next.xvalid = 1'b1;
				s_next.xfer.chan = f[3:0];
				s_next.xfer.src = s_next.ch[f[3:0]].src;
				s_next.xfer.dst = s_next.ch[f[3:0]].dst;
				s_next.xfer.width = s_next.ch[f[3:0]].ctrl[WIDTH_LSB +: 2];
			end
		end

		// axi read channel, one cycle after the address is taken
		if (s_reg.rvalid && rready)
			s_next.rvalid = 1'b0;
		if (arvalid && s_reg.arready)
		begin
			hit_r = int'(araddr[ADDR_W-1:CHAN_LSB]) < N;
			s_next.rvalid = 1'b1;
			s_next.rresp = hit_r ? RESP_OKAY : RESP_SLVERR;
			s_next.rdata = hit_r ? read_view(s_reg.ch[araddr[CHAN_LSB +: CHAN_W]],
				araddr[CHAN_LSB-1:0]) : 32'h0000_0000;
		end

		s_next.awready = !s_next.aw_full;
		s_next.wready = !s_next.w_full;
		s_next.arready = !s_next.rvalid;
	end

	function automatic logic [N-1:0] hi_mask(input state_s s);
		logic [N-1:0] m;
		for (int i = 0; i < N; i++)
			m[i] = s.ch[i].ctrl[PRIO_BIT];
		return m;
	endfunction

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign awready = s_reg.awready;
	assign wready  = s_reg.wready;
	assign bvalid  = s_reg.bvalid;
	assign bresp   = s_reg.bresp;
	assign arready = s_reg.arready;
	assign rvalid  = s_reg.rvalid;
	assign rdata   = s_reg.rdata;
	assign rresp   = s_reg.rresp;
	assign xfer_valid = s_reg.xvalid;
	assign xfer    = s_reg.xfer;

	generate
		for (genvar g = 0; g < N; g++)
		begin : g_busy
			assign chan_busy[g] = s_reg.ch[g].busy;
		end
	endgenerate

	// checks on channel 0 stand for every channel; the logic is indexed uniformly
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic acc0;
	assign acc0 = s_reg.xvalid && xfer_ready && s_reg.xfer.chan == 4'h0 && !wr_fire;

	a_busy_fall_count: assert property (
		$fell(s_reg.ch[0].busy) |-> $past(s_reg.ch[0].count) == 32'h0)
		else $error("busy fell with transfers left");

	a_src_step_width: assert property (
		acc0 && s_reg.ch[0].ctrl[SINC_BIT] && s_reg.ch[0].ctrl[WRAP_LSB +: 4] == 4'h0
		|=> s_reg.ch[0].src == $past(s_reg.ch[0].src) + ($past(s_reg.xfer.width) == WIDTH_BYTE
			? 32'h1 : $past(s_reg.xfer.width) == WIDTH_HALF ? 32'h2 : 32'h4))
		else $error("source pointer stepped by the wrong amount");

	a_src_fixed_addr: assert property (
		acc0 && !s_reg.ch[0].ctrl[SINC_BIT] && !s_reg.ch[0].ctrl[WRAP_SEL_BIT]
		|=> $stable(s_reg.ch[0].src))
		else $error("non-incrementing source pointer moved");

	a_wrap_high_bits: assert property (
		acc0 && !s_reg.ch[0].ctrl[WRAP_SEL_BIT] && s_reg.ch[0].ctrl[WRAP_LSB +: 4] != 4'h0
		|=> (s_reg.ch[0].src >> $past(s_reg.ch[0].ctrl[WRAP_LSB +: 4]))
			== ($past(s_reg.ch[0].src) >> $past(s_reg.ch[0].ctrl[WRAP_LSB +: 4])))
		else $error("wrapped pointer changed above the ring");

	a_issue_enabled: assert property (
		$rose(s_reg.xvalid) |-> s_reg.ch[s_reg.xfer.chan].ctrl[EN_BIT]
			&& s_reg.ch[s_reg.xfer.chan].busy)
		else $error("transfer issued for a disabled or idle channel");

	a_xfer_held: assert property (
		s_reg.xvalid && !xfer_ready |=> s_reg.xvalid && $stable(s_reg.xfer))
		else $error("transfer request dropped before acceptance");

	a_trig_start_load: assert property (
		wr_fire && wr_hit && s_reg.aw_addr == 12'h01c && wr_val != 32'h0
			&& s_reg.ch[0].ctrl[EN_BIT] && !(s_reg.xvalid && xfer_ready)
		|=> s_reg.ch[0].busy && s_reg.ch[0].count == $past(wr_val))
		else $error("trigger write did not start channel 0");

	a_nontrig_quiet: assert property (
		wr_fire && s_reg.aw_addr == 12'h024 && !s_reg.ch[0].busy && !trig_chain[0]
		|=> !s_reg.ch[0].busy)
		else $error("plain count write started channel 0");

	a_chain_fires: assert property (
		s_reg.ch[0].busy && s_reg.ch[0].count == 32'h0 && !(s_reg.xvalid && s_reg.xfer.chan == 4'h0)
			&& s_reg.ch[0].ctrl[CHAIN_LSB +: 4] == 4'h1 && s_reg.ch[1].ctrl[EN_BIT]
			&& !(wr_fire && s_reg.aw_addr[ADDR_W-1:CHAN_LSB] == 6'h01)
		|=> s_reg.ch[1].busy && s_reg.ch[1].count == $past(s_reg.ch[1].reload))
		else $error("completion of channel 0 did not start channel 1");
endmodule

// ===== fabric_model.sv
// far-side fabric model that completes transfer requests, promptly or with stalls
`timescale 1ns/10ps
module fabric_model
	import dma_alias_pkg::*;
(
	input  wire logic aclk,       // system clock
	input  wire logic aresetn,    // synchronous reset, active low
	input  wire logic slow,       // stall two cycles out of three
	output logic      xfer_ready  // transfer done this cycle
);
	typedef struct packed {
		logic [1:0] phase;
		logic       ready;
	} fab_s;
	fab_s st_reg;
	fab_s st_next;
	// a stalled fabric keeps the engine's request standing across several edges
	always_comb
	begin
		st_next = st_reg;
		st_next.phase = (st_reg.phase == 2'h2) ? 2'h0 : st_reg.phase + 2'h1;
		st_next.ready = !slow || (st_reg.phase == 2'h2);
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end
	assign xfer_ready = st_reg.ready;
endmodule

// ===== testbench.sv
// self-checking bench for the dma channel control block
`timescale 1ns/10ps
module testbench import dma_alias_pkg::*;;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = '0;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = '0;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready = 1'b0;
	logic [11:0] araddr = '0;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready = 1'b0;
	logic        xfer_valid;
	logic        xfer_ready;
	xfer_s       xfer;
	logic [11:0] chan_busy;
	logic        slow = 1'b0;
	int          fail_count = 0;
	int          n_checks = 0;
	xfer_s       q[$];

	always #10 aclk = ~aclk;

	dma_channel_ctrl #(.N(12)) u_dma_channel_ctrl (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .xfer_valid(xfer_valid),
		.xfer_ready(xfer_ready), .xfer(xfer), .chan_busy(chan_busy));

	fabric_model u_fabric_model (.aclk(aclk), .aresetn(aresetn), .slow(slow),
		.xfer_ready(xfer_ready));

	always @(posedge aclk)
	begin
		if (xfer_valid === 1'b1 && xfer_ready === 1'b1)
			q.push_back(xfer);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (!ad && awready === 1'b1)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		chk({30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge aclk);
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
		rready <= 1'b0;
	endtask

	task automatic wait_idle();
		int i;
		i = 0;
		while (chan_busy !== '0 && i < 500)
		begin
			@(posedge aclk);
			i++;
		end
		chk({20'h0, chan_busy}, 32'h0);
	endtask

	// model of where a pointer goes after one transfer
	function automatic logic [31:0] adv(input logic [31:0] p, input logic inc,
		input logic [1:0] w, input logic wr, input logic [3:0] ring);
		logic [31:0] m;
		logic [31:0] nx;
		m = (32'h1 << ring) - 32'h1;
		nx = p + (32'h1 << w);
		if (!inc)
			return p;
		if (wr && ring != 4'h0)
			return (p & ~m) | (nx & m);
		return nx;
	endfunction

	task automatic go(input int ch, input logic [3:0] ring, input logic sel,
		input logic dinc, input logic sinc, input logic [1:0] w,
		input logic [31:0] s, input logic [31:0] d, input logic [31:0] n);
		logic [11:0] b;
		b = 12'(ch * 64);
		axw(b + 12'h014, s);
		axw(b + 12'h018, d);
		axw(b + 12'h010, {17'h0, 4'(ch), sel, ring, dinc, sinc, w, 1'b0, 1'b1});
		q.delete();
		axw(b + 12'h01c, n);
		chk(32'(chan_busy[ch]), 32'h1);
		wait_idle();
		chk(32'(q.size()), n);
		for (int k = 0; k < q.size(); k++)
		begin
			chk(q[k].src, s);
			chk(q[k].dst, d);
			chk({26'h0, q[k].width, q[k].chan}, {26'h0, w, 4'(ch)});
			s = adv(s, sinc, w, !sel, ring);
			d = adv(d, dinc, w, sel, ring);
		end
	endtask

	task automatic t_regs();
		axr(12'h010, 32'h0);
		axw(12'h014, 32'h1234_5678);
		axr(12'h000, 32'h1234_5678);
		axr(12'h028, 32'h1234_5678);
		axw(12'h028, 32'h0bad_f00d);
		axr(12'h014, 32'h0bad_f00d);
		axw(12'h018, 32'h2222_0000);
		axr(12'h004, 32'h2222_0000);
		axw(12'h020, 32'h0000_7ff6);
		axr(12'h010, 32'h0000_7ff6);
		axr(12'h00c, 32'h0000_7ff6);
		axw(12'h024, 32'h0000_0005);
		axr(12'h01c, 32'h0);
		chk({20'h0, chan_busy}, 32'h0);
		axw(12'h050, 32'h0000_0040);
		axr(12'h060, 32'h0000_0040);
		axw(12'h2d0, 32'h0000_0012);
		axr(12'h2e0, 32'h0000_0012);
		axw(12'h300, 32'h1, RESP_SLVERR);
		axr(12'h300, 32'h0, RESP_SLVERR);
	endtask

	task automatic t_moves();
		for (int w = 0; w < 3; w++)
			go(0, 4'h0, 1'b0, 1'b1, 1'b1, 2'(w), 32'h1000, 32'h2000, 3);
		q.delete();
		axw(12'h00c, 32'h0000_0039);
		wait_idle();
		chk(32'(q.size()), 32'h3);
		go(2, 4'h0, 1'b0, 1'b1, 1'b0, 2'h2, 32'h5000, 32'h6000, 2);
		go(3, 4'h0, 1'b0, 1'b0, 1'b1, 2'h1, 32'h5000, 32'h6000, 2);
		slow <= 1'b1;
		go(4, 4'h2, 1'b0, 1'b1, 1'b1, 2'h2, 32'h7008, 32'h8008, 4);
		go(5, 4'h2, 1'b1, 1'b1, 1'b1, 2'h2, 32'h7008, 32'h8008, 4);
		go(6, 4'h1, 1'b0, 1'b1, 1'b1, 2'h0, 32'h9001, 32'ha000, 3);
		go(7, 4'hf, 1'b1, 1'b1, 1'b1, 2'h2, 32'hb000, 32'hfffc, 2);
		slow <= 1'b0;
	endtask

	task automatic t_chain_off();
		axw(12'h054, 32'h3000);
		axw(12'h058, 32'h4000);
		axw(12'h050, 32'h0000_0831);
		axw(12'h064, 32'h2);
		axw(12'h010, 32'h0000_0831);
		q.delete();
		axw(12'h01c, 32'h1);
		wait_idle();
		chk(32'(q.size()), 32'h3);
		if (q.size() == 3)
		begin
			chk({28'h0, q[1].chan}, 32'h1);
			chk(q[2].src, 32'h3001);
		end
		axw(12'h210, 32'h0000_4030);
		q.delete();
		axw(12'h21c, 32'h3);
		repeat (6) @(posedge aclk);
		chk({20'h0, chan_busy}, 32'h0);
		chk(32'(q.size()), 32'h0);
	endtask

	// two preferred channels and one plain one compete; once all run, picks repeat in threes
	task automatic t_prio();
		int f;
		int lo;
		int hi;
		f = -1;
		lo = 0;
		hi = 0;
		axw(12'h250, 32'h0000_4839);
		axw(12'h290, 32'h0000_503b);
		axw(12'h2d0, 32'h0000_583b);
		q.delete();
		axw(12'h25c, 32'h0000_0014);
		axw(12'h29c, 32'h0000_0014);
		axw(12'h2dc, 32'h0000_0014);
		wait_idle();
		chk(32'(q.size()), 32'h0000_003c);
		foreach (q[k])
			if (f < 0 && q[k].chan == 4'hb)
				f = k;
		for (int k = f; k >= 0 && k < f + 9 && k < q.size(); k++)
		begin
			lo += int'(q[k].chan == 4'h9);
			hi += int'(q[k].chan == 4'ha);
		end
		chk(32'(lo), 32'h3);
		chk(32'(hi), 32'h3);
		axw(12'h26c, 32'h0);
		chk({20'h0, chan_busy}, 32'h0);
		q.delete();
		axw(12'h27c, 32'h0000_0100);
		wait_idle();
		chk(32'(q.size()), 32'h0000_0014);
		chk(q[0].src, 32'h0000_0100);
	endtask

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_moves();
		t_chain_off();
		t_prio();
		finish_test();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		finish_test();
	end
endmodule
